/* File: hdl/phy_link_config_control.sv */
`timescale 1ns/100ps
`default_nettype none
`include "phy_link_consts.svh"
module phy_link_config_control import phy_link_pkg::*; #(
  parameter int BREAK_CYCLES = `MS_CYCLES(`BREAK_MS),
  parameter int NEGO_CYCLES = `MS_CYCLES(`NEGO_MS),
  parameter int LOSS_CYCLES = `MS_CYCLES(`LINK_LOSS_MS),
  parameter int BLINK_CYCLES = `MS_CYCLES(`BLINK_MS)
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Serial management
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  // MAC transmit
  input wire logic tx_en,
  input wire logic [3:0] txd,
  // MAC receive pins, straps shared
  input wire logic [3:0] rxd_in,
  output logic [3:0] rxd_out,
  output logic rxd_oe,
  input wire logic col_in,
  output logic col_out,
  output logic col_oe,
  input wire logic crs_in,
  output logic crs_out,
  output logic crs_oe,
  input wire logic rx_er_in,
  output logic rx_er_out,
  output logic rx_er_oe,
  output logic rx_dv_out,
  output logic rx_dv_oe,
  output logic mii_clk_oe,
  // Indicator pin, negotiation strap shared
  input wire logic ind_in,
  output logic ind_out,
  output logic ind_oe,
  // Media side
  input wire logic link_pulse,
  input wire logic valid_packet,
  input wire logic signal_detect,
  input wire logic line_rx_dv,
  input wire logic [3:0] line_rxd,
  input wire logic line_rx_er,
  input wire logic partner_page,
  input wire logic [3:0] partner_ability,
  output logic line_tx_en,
  output logic [3:0] line_txd,
  output logic line_silent,
  output logic flp_enable,
  output logic crossover_sel,
  output logic speed_100,
  output logic full_duplex
);
  mgmt_if mg ();
  logic tmr_load, tmr_expired, rnd;
  tick_t tmr_val;

  mdio_slave u_mdio (
    .clock(clock),
    .rst_b(rst_b),
    .mdc(mdc),
    .mdio_in(mdio_in),
    .mdio_out(mdio_out),
    .mdio_oe(mdio_oe),
    .mg(mg)
  );

  link_timer u_timer (
    .clock(clock),
    .rst_b(rst_b),
    .load(tmr_load),
    .load_val(tmr_val),
    .expired(tmr_expired),
    .rnd(rnd)
  );

  // Registers and straps
  logic strap_done_r, strap_done_next, iso_strap_r, iso_strap_next;
  logic neg_strap_r, neg_strap_next, ind_mode_r, ind_mode_next;
  logic xo_auto_r, xo_auto_next, xo_force_r, xo_force_next;
  logic ind_ovr_r, ind_ovr_next, ind_val_r, ind_val_next;
  logic [15:0] basic_mode_control_r, basic_mode_control_next;
  logic [3:0] advertisement_register_r, advertisement_register_next;
  logic [4:0] addr_r, addr_next;
  logic restart_taken, an_en, iso, link_good, link_ok;

  assign an_en = basic_mode_control_r[`BASIC_AN_EN];
  assign iso = basic_mode_control_r[`BASIC_ISOLATE] | iso_strap_r;
  assign mg.station = addr_r;

  always_comb begin
    strap_done_next = 1'b1;
    iso_strap_next = iso_strap_r;
    neg_strap_next = neg_strap_r;
    ind_mode_next = ind_mode_r;
    xo_auto_next = xo_auto_r;
    xo_force_next = xo_force_r;
    ind_ovr_next = ind_ovr_r;
    ind_val_next = ind_val_r;
    basic_mode_control_next = basic_mode_control_r;
    advertisement_register_next = advertisement_register_r;
    addr_next = addr_r;
    if (!strap_done_r) begin
      addr_next = {rxd_in, col_in};
      iso_strap_next = ({rxd_in, col_in} == 5'h00);
      neg_strap_next = ind_in;
      advertisement_register_next = ind_in ? `ADV_ALL : `ADV_HALF_ONLY;
      ind_mode_next = crs_in;
      xo_auto_next = rx_er_in;
    end
    if (restart_taken) begin
      basic_mode_control_next[`BASIC_RESTART] = 1'b0;
    end
    if (mg.wr) begin
      case (mg.reg_addr)
        `REG_BASIC: begin
          basic_mode_control_next = mg.wdata;
          basic_mode_control_next[`BASIC_RESTART] = mg.wdata[`BASIC_AN_EN] & (mg.wdata[`BASIC_RESTART]
            | ~basic_mode_control_r[`BASIC_AN_EN] | (basic_mode_control_r[`BASIC_RESTART] & ~restart_taken));
        end
        `REG_ADV: advertisement_register_next = mg.wdata[8:5];
        `REG_IND: begin
          ind_ovr_next = mg.wdata[`IND_OVERRIDE];
          ind_val_next = mg.wdata[`IND_VALUE];
        end
        `REG_PHY_CTRL: begin
          xo_auto_next = mg.wdata[`CTRL_XOVER_AUTO];
          xo_force_next = mg.wdata[`CTRL_XOVER_FORCE];
          ind_mode_next = mg.wdata[`CTRL_IND_MODE];
          addr_next = mg.wdata[4:0];
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      strap_done_r <= 1'b0;
      iso_strap_r <= 1'b0;
      neg_strap_r <= 1'b0;
      ind_mode_r <= 1'b1;
      xo_auto_r <= 1'b1;
      xo_force_r <= 1'b0;
      ind_ovr_r <= 1'b0;
      ind_val_r <= 1'b0;
      basic_mode_control_r <= `BASIC_RESET;
      advertisement_register_r <= `ADV_ALL;
      addr_r <= `ADDR_RESET;
    end else begin
      strap_done_r <= strap_done_next;
      iso_strap_r <= iso_strap_next;
      neg_strap_r <= neg_strap_next;
      ind_mode_r <= ind_mode_next;
      xo_auto_r <= xo_auto_next;
      xo_force_r <= xo_force_next;
      ind_ovr_r <= ind_ovr_next;
      ind_val_r <= ind_val_next;
      basic_mode_control_r <= basic_mode_control_next;
      advertisement_register_r <= advertisement_register_next;
      addr_r <= addr_next;
    end
  end

  // Negotiation
  nego_state_e st_r, st_next;
  logic spd_r, spd_next, dup_r, dup_next, done_r, done_next, mdix_r, mdix_next;
  logic link10_r;
  logic [3:0] common;

  assign common = advertisement_register_r & partner_ability;
  assign link_ok = spd_r ? signal_detect : link10_r;

  always_comb begin
    st_next = st_r;
    spd_next = spd_r;
    dup_next = dup_r;
    done_next = done_r;
    mdix_next = mdix_r;
    tmr_load = 1'b0;
    tmr_val = tick_t'(NEGO_CYCLES);
    restart_taken = 1'b0;
    if (!an_en) begin
      st_next = NEG_OFF;
      done_next = 1'b0;
      spd_next = basic_mode_control_r[`BASIC_SPEED];
      dup_next = basic_mode_control_r[`BASIC_DUPLEX];
    end else if (basic_mode_control_r[`BASIC_RESTART]) begin
      restart_taken = 1'b1;
      st_next = NEG_BREAK;
      done_next = 1'b0;
      tmr_load = 1'b1;
      tmr_val = tick_t'(BREAK_CYCLES);
    end else begin
      case (st_r)
        NEG_OFF: begin
          st_next = NEG_ABILITY;
          tmr_load = 1'b1;
        end
        NEG_BREAK: begin
          if (tmr_expired) begin
            st_next = NEG_ABILITY;
            tmr_load = 1'b1;
          end
        end
        NEG_ABILITY: begin
          if (partner_page && common != 4'h0) begin
            st_next = NEG_LINK;
            done_next = 1'b1;
            spd_next = common[3] | common[2];
            dup_next = common[3] | (~common[2] & common[1]);
          end else if (signal_detect || link10_r) begin
            st_next = NEG_LINK;
            done_next = 1'b1;
            spd_next = signal_detect;
            dup_next = 1'b0;
          end else if (tmr_expired) begin
            tmr_load = 1'b1;
            mdix_next = xo_auto_r ? rnd : mdix_r;
          end
        end
        NEG_LINK: begin
          if (!link_ok) begin
            st_next = NEG_ABILITY;
            done_next = 1'b0;
            tmr_load = 1'b1;
          end
        end
        default: st_next = NEG_OFF;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= NEG_OFF;
      spd_r <= 1'b1;
      dup_r <= 1'b1;
      done_r <= 1'b0;
      mdix_r <= 1'b0;
    end else begin
      st_r <= st_next;
      spd_r <= spd_next;
      dup_r <= dup_next;
      done_r <= done_next;
      mdix_r <= mdix_next;
    end
  end

  assign link_good = (st_r == NEG_LINK) | (~an_en & link_ok);

  // Link pulses and indicator
  logic link10_next, ind_r, ind_next;
  logic [2:0] pcnt_r, pcnt_next;
  tick_t loss_r, loss_next, blink_r, blink_next;
  logic activity, lit;

  assign activity = (tx_en & ~iso) | line_rx_dv;

  always_comb begin
    loss_next = (loss_r == '0) ? loss_r : loss_r - tick_t'(1);
    pcnt_next = pcnt_r;
    link10_next = link10_r;
    blink_next = (blink_r == '0) ? blink_r : blink_r - tick_t'(1);
    if (link_pulse || valid_packet) begin
      loss_next = tick_t'(LOSS_CYCLES);
      if (link_pulse && pcnt_r != `LINK_PULSES) begin
        pcnt_next = pcnt_r + 3'h1;
      end
      if (valid_packet || pcnt_r == `LINK_PULSES - 3'h1) begin
        link10_next = 1'b1;
      end
    end else if (loss_r == tick_t'(1)) begin
      pcnt_next = 3'h0;
      link10_next = 1'b0;
    end
    if (activity && blink_r == '0) begin
      blink_next = tick_t'(2 * BLINK_CYCLES);
    end
    lit = link_good & (ind_mode_r | (blink_r <= tick_t'(BLINK_CYCLES)));
    if (ind_ovr_r) begin
      lit = ind_val_r;
    end
    ind_next = lit ^ neg_strap_r;
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      loss_r <= '0;
      pcnt_r <= 3'h0;
      link10_r <= 1'b0;
      blink_r <= '0;
      ind_r <= 1'b0;
    end else begin
      loss_r <= loss_next;
      pcnt_r <= pcnt_next;
      link10_r <= link10_next;
      blink_r <= blink_next;
      ind_r <= ind_next;
    end
  end

  // Register reads; the indicator register returns its own bits, never the pin
  always_comb begin
    case (mg.reg_addr)
      `REG_BASIC: mg.rdata = basic_mode_control_r;
      `REG_STATUS: mg.rdata = `STATUS_FIXED | (16'(link_good) << `STATUS_LINK) | (16'(done_r) << `STATUS_AN_DONE);
      `REG_ADV: mg.rdata = {7'h00, advertisement_register_r, `ADV_SELECTOR};
      `REG_PHY_STATUS: mg.rdata = (16'(link_good) << `PSTS_LINK) | (16'(!spd_r) << `PSTS_SPEED10)
        | (16'(dup_r) << `PSTS_DUPLEX) | (16'(crossover_sel) << `PSTS_XOVER);
      `REG_IND: mg.rdata = (16'(ind_ovr_r) << `IND_OVERRIDE) | (16'(ind_val_r) << `IND_VALUE);
      `REG_PHY_CTRL: mg.rdata = (16'(xo_auto_r) << `CTRL_XOVER_AUTO) | (16'(xo_force_r) << `CTRL_XOVER_FORCE)
        | (16'(ind_mode_r) << `CTRL_IND_MODE) | {11'h000, addr_r};
      default: mg.rdata = 16'h0000;
    endcase
  end

  // MAC and media outputs
  logic [3:0] rxd_q, txd_q;
  logic crs_q, col_q, rx_er_q, rx_dv_q, tx_en_q, silent_q, xo_q;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rxd_q <= 4'h0;
      txd_q <= 4'h0;
      crs_q <= 1'b0;
      col_q <= 1'b0;
      rx_er_q <= 1'b0;
      rx_dv_q <= 1'b0;
      tx_en_q <= 1'b0;
      silent_q <= 1'b0;
      xo_q <= 1'b0;
    end else begin
      rxd_q <= line_rxd;
      rx_er_q <= line_rx_er;
      rx_dv_q <= line_rx_dv;
      crs_q <= line_rx_dv | (tx_en & ~dup_r);
      col_q <= line_rx_dv & tx_en & ~dup_r;
      // no data while isolated
      // Next state keeps silence aligned with the state, so it never overlaps bursts
      tx_en_q <= tx_en & ~iso & (st_next != NEG_BREAK);
      txd_q <= (iso || st_next == NEG_BREAK) ? 4'h0 : txd;
      silent_q <= (st_next == NEG_BREAK);
      // force wins; auto only when negotiating
      xo_q <= xo_force_r | (xo_auto_r & an_en & mdix_r);
    end
  end

  assign rxd_oe = strap_done_r & ~iso;
  assign col_oe = strap_done_r & ~iso;
  assign crs_oe = strap_done_r & ~iso;
  assign rx_er_oe = strap_done_r & ~iso;
  assign rx_dv_oe = strap_done_r & ~iso;
  assign mii_clk_oe = strap_done_r & ~iso;
  assign rxd_out = rxd_q;
  assign col_out = col_q;
  assign crs_out = crs_q;
  assign rx_er_out = rx_er_q;
  assign rx_dv_out = rx_dv_q;
  assign ind_out = ind_r;
  assign ind_oe = strap_done_r;
  assign line_tx_en = tx_en_q;
  assign line_txd = txd_q;
  assign line_silent = silent_q;
  assign flp_enable = (st_r == NEG_ABILITY);
  assign crossover_sel = xo_q;
  assign speed_100 = spd_r;
  assign full_duplex = dup_r;
endmodule
`default_nettype wire

/* File: hdl/phy_link_consts.svh */
`ifndef PHY_LINK_CONSTS_SVH
`define PHY_LINK_CONSTS_SVH
`define CLK_HZ 50000000
`define MS_CYCLES(ms) ((ms) * (`CLK_HZ / 1000))
`define BREAK_MS 1500
`define NEGO_MS 3000
`define LINK_LOSS_MS 100
`define BLINK_MS 50
`define LINK_PULSES 3'h7
`define PREAMBLE_BITS 6'h20
`define REG_BASIC 5'h00
`define REG_STATUS 5'h01
`define REG_ADV 5'h04
`define REG_PHY_STATUS 5'h10
`define REG_IND 5'h18
`define REG_PHY_CTRL 5'h19
`define BASIC_SPEED 13
`define BASIC_AN_EN 12
`define BASIC_ISOLATE 10
`define BASIC_RESTART 9
`define BASIC_DUPLEX 8
`define BASIC_RESET 16'h3100
`define STATUS_FIXED 16'h7809
`define STATUS_LINK 2
`define STATUS_AN_DONE 5
`define ADV_SELECTOR 5'h01
`define ADV_HALF_ONLY 4'h5
`define ADV_ALL 4'hf
`define PSTS_LINK 0
`define PSTS_SPEED10 1
`define PSTS_DUPLEX 2
`define PSTS_XOVER 14
`define CTRL_XOVER_AUTO 15
`define CTRL_XOVER_FORCE 14
`define CTRL_IND_MODE 5
`define IND_OVERRIDE 4
`define IND_VALUE 1
`define ADDR_RESET 5'h01
`endif

/* File: hdl/phy_link_pkg.sv */
package phy_link_pkg;
  typedef enum logic [1:0] {NEG_OFF, NEG_BREAK, NEG_ABILITY, NEG_LINK} nego_state_e;
  typedef enum logic [1:0] {MD_PRE, MD_HDR, MD_TA, MD_DATA} mdio_state_e;
  typedef logic [27:0] tick_t;
endpackage

/* File: hdl/mgmt_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface mgmt_if;
  logic [4:0] reg_addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic wr;
  logic rd;
  logic [4:0] station;
  modport engine(output reg_addr, wdata, wr, rd, input rdata, station);
  modport regs(input reg_addr, wdata, wr, rd, output rdata, station);
endinterface
`default_nettype wire

/* File: hdl/link_timer.sv */
`timescale 1ns/100ps
`default_nettype none
module link_timer import phy_link_pkg::*; (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Control
  input wire logic load,
  input wire tick_t load_val,
  // Results
  output logic expired,
  output logic rnd
);
  tick_t cnt_r, cnt_next;
  logic exp_r, exp_next;
  logic [15:0] lfsr_r, lfsr_next;

  always_comb begin
    cnt_next = (cnt_r == '0) ? cnt_r : cnt_r - tick_t'(1);
    exp_next = (cnt_r == tick_t'(1));
    if (load) begin
      cnt_next = load_val;
      exp_next = 1'b0;
    end
    // Free-running sequence; sampled at unrelated moments it acts as a seed
    lfsr_next = {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[14] ^ lfsr_r[12] ^ lfsr_r[3]};
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= '0;
      exp_r <= 1'b0;
      lfsr_r <= 16'h0001;
    end else begin
      cnt_r <= cnt_next;
      exp_r <= exp_next;
      lfsr_r <= lfsr_next;
    end
  end

  assign expired = exp_r;
  assign rnd = lfsr_r[0];
endmodule
`default_nettype wire

/* File: hdl/mdio_slave.sv */
`timescale 1ns/100ps
`default_nettype none
`include "phy_link_consts.svh"
module mdio_slave import phy_link_pkg::*; (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Serial management pins
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  // Register side
  mgmt_if.engine mg
);
  mdio_state_e st_r, st_next;
  logic [5:0] cnt_r, cnt_next;
  logic [15:0] sr_r, sr_next;
  logic [4:0] addr_r, addr_next;
  logic op_rd_r, op_rd_next, oe_r, oe_next, out_r, out_next;
  logic wr_r, wr_next, rd_r, rd_next, mdc_q;
  logic rise;
  logic [12:0] hdr;

  assign rise = mdc & ~mdc_q;
  assign hdr = {sr_r[11:0], mdio_in};

  always_comb begin
    st_next = st_r;
    cnt_next = cnt_r;
    sr_next = sr_r;
    addr_next = addr_r;
    op_rd_next = op_rd_r;
    oe_next = oe_r;
    out_next = out_r;
    wr_next = 1'b0;
    rd_next = 1'b0;
    if (rise) begin
      case (st_r)
        MD_PRE: begin
          if (mdio_in) begin
            cnt_next = (cnt_r == `PREAMBLE_BITS) ? cnt_r : cnt_r + 6'h01;
          end else if (cnt_r == `PREAMBLE_BITS) begin
            st_next = MD_HDR;
            cnt_next = 6'h00;
            sr_next = 16'h0000;
          end else begin
            cnt_next = 6'h00;
          end
        end
        MD_HDR: begin
          sr_next = {sr_r[14:0], mdio_in};
          cnt_next = cnt_r + 6'h01;
          if (cnt_r == 6'h0c) begin
            cnt_next = 6'h00;
            addr_next = hdr[4:0];
            op_rd_next = (hdr[11:10] == 2'b10);
            if (hdr[12] && hdr[9:5] == mg.station && (hdr[11:10] == 2'b10 || hdr[11:10] == 2'b01)) begin
              st_next = MD_TA;
              rd_next = (hdr[11:10] == 2'b10);
            end else begin
              st_next = MD_PRE;
            end
          end
        end
        MD_TA: begin
          cnt_next = cnt_r + 6'h01;
          if (op_rd_r) begin
            oe_next = 1'b1;
            if (cnt_r == 6'h00) begin
              out_next = 1'b0;
              sr_next = mg.rdata;
            end else begin
              out_next = sr_r[15];
              sr_next = {sr_r[14:0], 1'b0};
            end
          end
          if (cnt_r == 6'h01) begin
            st_next = MD_DATA;
            cnt_next = 6'h00;
          end
        end
        MD_DATA: begin
          cnt_next = cnt_r + 6'h01;
          sr_next = {sr_r[14:0], op_rd_r ? 1'b0 : mdio_in};
          out_next = sr_r[15];
          if (cnt_r == 6'h0f) begin
            st_next = MD_PRE;
            cnt_next = 6'h00;
            oe_next = 1'b0;
            out_next = 1'b0;
            wr_next = ~op_rd_r;
          end
        end
        default: st_next = MD_PRE;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= MD_PRE;
      cnt_r <= 6'h00;
      sr_r <= 16'h0000;
      addr_r <= 5'h00;
      op_rd_r <= 1'b0;
      oe_r <= 1'b0;
      out_r <= 1'b0;
      wr_r <= 1'b0;
      rd_r <= 1'b0;
      // Clock idles high after a frame; starting high avoids a false rise
      mdc_q <= 1'b1;
    end else begin
      st_r <= st_next;
      cnt_r <= cnt_next;
      sr_r <= sr_next;
      addr_r <= addr_next;
      op_rd_r <= op_rd_next;
      oe_r <= oe_next;
      out_r <= out_next;
      wr_r <= wr_next;
      rd_r <= rd_next;
      mdc_q <= mdc;
    end
  end

  assign mg.reg_addr = addr_r;
  assign mg.wdata = sr_r;
  assign mg.wr = wr_r;
  assign mg.rd = rd_r;
  assign mdio_out = out_r;
  assign mdio_oe = oe_r;
endmodule
`default_nettype wire

/* File: test/phy_link_sva.sv */
`timescale 1ns/100ps
`default_nettype none
module phy_link_sva #(
  parameter int BREAK_CYCLES = 50
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // MAC side
  input wire logic tx_en,
  input wire logic crs_out,
  input wire logic crs_oe,
  input wire logic col_out,
  input wire logic col_oe,
  input wire logic rxd_oe,
  input wire logic rx_dv_oe,
  input wire logic mii_clk_oe,
  // Management
  input wire logic mdio_out,
  input wire logic mdio_oe,
  // Media side
  input wire logic line_rx_dv,
  input wire logic line_tx_en,
  input wire logic line_silent,
  input wire logic flp_enable,
  input wire logic full_duplex
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  int run;
  // Length of the current silent stretch
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      run <= 0;
    end else begin
      run <= line_silent ? run + 1 : 0;
    end
  end
  sequence turn_hold;
    !mdio_out ##1 mdio_oe [*4];
  endsequence
  sequence break_end;
    $fell(line_silent);
  endsequence
  a_mdio_turn: assert property ($rose(mdio_oe) |-> turn_hold)
    else $error("turnaround bit wrong");
  a_break_len: assert property (break_end |-> run >= BREAK_CYCLES - 1 && run <= BREAK_CYCLES + 1)
    else $error("break length wrong");
  a_silent_flp: assert property (line_silent |-> !flp_enable)
    else $error("bursts during break");
  a_silent_tx: assert property (line_silent |-> !line_tx_en)
    else $error("transmit during break");
  a_crs_rule: assert property (crs_oe && $past(crs_oe) |-> crs_out == $past(line_rx_dv | (tx_en & ~full_duplex)))
    else $error("carrier sense wrong");
  a_col_rule: assert property (col_oe && $past(col_oe) |-> col_out == $past(line_rx_dv & tx_en & ~full_duplex))
    else $error("collision wrong");
  a_oe_group: assert property (rxd_oe == crs_oe && rxd_oe == col_oe && rxd_oe == rx_dv_oe && rxd_oe == mii_clk_oe)
    else $error("release not uniform");
  a_iso_tx: assert property (!rxd_oe && $past(!rxd_oe) |-> !line_tx_en)
    else $error("isolated data sent");
endmodule
bind phy_link_config_control phy_link_sva #(.BREAK_CYCLES(BREAK_CYCLES)) sva (.*);
`default_nettype wire

/* File: test/mgmt_station.sv */
`timescale 1ns/100ps
`default_nettype none
module mgmt_station (
  // Clock
  input wire logic clock,
  // Management pins
  output logic mdc,
  output logic mdio_drv,
  output logic mdio_en,
  input wire logic mdio_bus
);
  initial begin
    mdc = 1'h0;
    mdio_drv = 1'h1;
    mdio_en = 1'h0;
  end
  task automatic frame(input logic rd, input logic [4:0] phy, input logic [4:0] ra, input logic [15:0] wd,
                       output logic [15:0] q);
    logic [63:0] f;
    f = {32'hffffffff, 2'h1, rd, ~rd, phy, ra, 2'h2, wd};
    q = 16'h0;
    for (int k = 0; k < 64; k++) begin
      @(negedge clock);
      mdc = 1'h0;
      mdio_drv = f[63 - k];
      mdio_en = !(rd && k >= 46);
      repeat (4) @(negedge clock);
      q = (k >= 48) ? {q[14:0], mdio_bus} : q;
      mdc = 1'h1;
      repeat (3) @(negedge clock);
    end
    mdio_en = 1'h0;
  endtask
endmodule
`default_nettype wire

/* File: test/phy_link_config_control_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module phy_link_config_control_tb;
  logic clock = 1'h0, rst_b = 1'h0, tx_en = 1'h0, line_rx_dv = 1'h0, line_rx_er = 1'h0;
  logic link_pulse = 1'h0, valid_packet = 1'h0, signal_detect = 1'h0, partner_page = 1'h0;
  logic col_in = 1'h1, crs_in = 1'h1, rx_er_in = 1'h1, ind_in = 1'h0;
  logic [3:0] txd = 4'h0, rxd_in = 4'h1, line_rxd = 4'h0, partner_ability = 4'h0;
  logic mdio_out, mdio_oe, rxd_oe, col_out, col_oe, crs_out, crs_oe, rx_er_out, rx_er_oe;
  logic rx_dv_out, rx_dv_oe, mii_clk_oe, ind_out, ind_oe, line_tx_en, line_silent;
  logic flp_enable, crossover_sel, speed_100, full_duplex, mdc, mdio_drv, mdio_en;
  logic [3:0] rxd_out, line_txd;
  logic [4:0] adr = 5'h03;
  logic [15:0] q;
  wire mdio_in;
  int num_errors, total_checks, cyc;
  // Pull-up on the shared data line
  assign mdio_in = mdio_oe ? mdio_out : (mdio_en ? mdio_drv : 1'h1);
  always #10 clock = ~clock;
  phy_link_config_control #(.BREAK_CYCLES(50), .NEGO_CYCLES(200), .LOSS_CYCLES(30), .BLINK_CYCLES(8)) dut (.*);
  mgmt_station st (.clock(clock), .mdc(mdc), .mdio_drv(mdio_drv), .mdio_en(mdio_en), .mdio_bus(mdio_in));
  task automatic chk(string n, logic [15:0] e, logic [15:0] s);
    total_checks++;
    if (s !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(logic [4:0] a, logic [15:0] d);
    logic [15:0] t;
    st.frame(1'h0, adr, a, d, t);
  endtask
  task automatic rd(logic [4:0] a);
    st.frame(1'h1, adr, a, 16'h0, q);
  endtask
  task automatic await(ref logic s, input logic v);
    for (int i = 0; i < 400 && s !== v; i++) @(negedge clock);
  endtask
  task automatic settle;
    repeat (3) @(negedge clock);
  endtask
  task automatic t_regs;
    rd(5'h19);
    chk("phy_control", 16'h8023, q & 16'hc03f);
    rd(5'h04);
    chk("advert", 16'h00a1, q & 16'h01ff);
    adr = 5'h04;
    rd(5'h00);
    chk("wrong station", 16'hffff, q);
    adr = 5'h03;
    wr(5'h18, 16'h0012);
    rd(5'h18);
    chk("direct reg", 16'h0012, q);
    chk("ind pin", 16'h1, ind_out);
    wr(5'h18, 16'h0000);
    $display("done regs");
  endtask
  task automatic t_link;
    for (int i = 1; i <= 7; i++) begin
      link_pulse = 1'h1;
      @(negedge clock);
      link_pulse = 1'h0;
      settle();
      chk("link ind", 16'(i == 7), ind_out);
      repeat (6) @(negedge clock);
    end
    await(full_duplex, 1'h0);
    chk("parallel", 16'h0, {speed_100, full_duplex, flp_enable});
    repeat (40) @(negedge clock);
    chk("loss ind", 16'h0, ind_out);
    await(flp_enable, 1'h1);
    chk("resume", 16'h1, flp_enable);
    valid_packet = 1'h1;
    @(negedge clock);
    valid_packet = 1'h0;
    settle();
    chk("packet ind", 16'h1, ind_out);
    $display("done link");
  endtask
  task automatic t_restart;
    wr(5'h00, 16'h3300);
    await(line_silent, 1'h1);
    chk("break", 16'h1, line_silent);
    await(line_silent, 1'h0);
    chk("bursts", 16'h1, flp_enable);
    partner_ability = 4'hf;
    partner_page = 1'h1;
    @(negedge clock);
    partner_page = 1'h0;
    settle();
    chk("resolved", 16'h2, {speed_100, full_duplex});
    rd(5'h00);
    chk("restart clear", 16'h0, q[9]);
    rd(5'h10);
    chk("phy status", 16'h0, q & 16'h0007);
    $display("done restart");
  endtask
  task automatic t_duplex;
    wr(5'h00, 16'h2100);
    tx_en = 1'h1;
    txd = 4'h5;
    settle();
    chk("full tx", 16'hc5, {speed_100, full_duplex, crs_out, col_out, line_txd});
    line_rx_dv = 1'h1;
    line_rxd = 4'ha;
    line_rx_er = 1'h1;
    settle();
    chk("full rx", 16'hda, {rx_dv_out, crs_out, col_out, rx_er_out, rxd_out});
    wr(5'h00, 16'h2000);
    settle();
    chk("half col", 16'h3, {full_duplex, crs_out, col_out});
    line_rx_dv = 1'h0;
    settle();
    chk("half crs", 16'h2, {crs_out, col_out});
    tx_en = 1'h0;
    wr(5'h19, 16'h4023);
    chk("force cross", 16'h1, crossover_sel);
    wr(5'h00, 16'h0000);
    wr(5'h00, 16'h1000);
    chk("enable", 16'h1, line_silent);
    $display("done duplex");
  endtask
  task automatic t_iso;
    wr(5'h00, 16'h1400);
    tx_en = 1'h1;
    settle();
    chk("isolated", 16'h0, {rxd_oe, rx_er_oe, line_tx_en});
    rd(5'h00);
    chk("iso mgmt", 16'h1, q[10]);
    tx_en = 1'h0;
    wr(5'h00, 16'h1000);
    wr(5'h19, 16'h8020);
    adr = 5'h00;
    rd(5'h19);
    chk("zero written", 16'h20, {rxd_oe, q[4:0]});
    $display("done isolate");
  endtask
  task automatic t_strap0;
    rst_b = 1'h0;
    rxd_in = 4'h0;
    col_in = 1'h0;
    crs_in = 1'h0;
    ind_in = 1'h1;
    settle();
    rst_b = 1'h1;
    settle();
    chk("strap iso", 16'h1, {rxd_oe, ind_oe});
    chk("polarity", 16'h1, ind_out);
    rd(5'h19);
    chk("strap addr", 16'h8000, q & 16'hc03f);
    rd(5'h04);
    chk("advert all", 16'h01e1, q & 16'h01ff);
    $display("done strap");
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc == 40000) begin
      num_errors++;
      summarize();
    end
  end
  initial begin
    repeat (8) @(negedge clock);
    rst_b = 1'h1;
    settle();
    t_regs();
    t_link();
    t_restart();
    t_duplex();
    t_iso();
    t_strap0();
    summarize();
  end
endmodule
`default_nettype wire
